// [pwc_pkg.sv]
package pwc_pkg;

    // Register offsets, one aligned 32-bit word each.
    localparam logic [7:0] OFS_SYS_CLK_DIV = 8'h00;
    localparam logic [7:0] OFS_PLL_FACTOR = 8'h04;
    localparam logic [7:0] OFS_OSC_RUN = 8'h08;
    localparam logic [7:0] OFS_SUB_OSC_STOP = 8'h0C;
    localparam logic [7:0] OFS_OSC_STABLE = 8'h10;
    localparam logic [7:0] OFS_MAIN_WAIT = 8'h14;
    localparam logic [7:0] OFS_SLOW_FORCE = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

    // Field positions.
    localparam int EB_DIV_LSB = 16;
    localparam int BUS_PIN_BIT = 23;
    localparam int PA_DIV_LSB = 24;
    localparam int MULT_LSB = 8;
    localparam int IN_DIV_LSB = 0;
    localparam int RUN_MAIN_STOP_BIT = 0;
    localparam int RUN_PLL_STOP_BIT = 1;
    localparam int RUN_USB_STOP_BIT = 2;
    localparam int ST_MAIN_BIT = 0;
    localparam int ST_PLL_BIT = 1;
    localparam int ST_USB_BIT = 2;

    // Encodings and reset values.
    localparam logic [5:0] MULT_CODE_MIN = 6'h07;
    localparam logic [5:0] MULT_CODE_STD_MAX = 6'h17;
    localparam logic [5:0] MULT_CODE_EXT_MAX = 6'h1A;
    localparam logic [5:0] MULT_RST = 6'h07;
    localparam logic [1:0] IN_DIV_ILLEGAL = 2'h3;
    localparam logic [4:0] WAIT_CODE_DOUBLE_MAX = 5'h07;
    localparam logic [4:0] WAIT_CODE_STD_LONG = 5'h08;
    localparam logic [4:0] WAIT_RST = 5'h05;
    localparam logic [17:0] WAIT_STD_ZERO = 18'h00000;
    localparam logic [17:0] WAIT_EXT_ZERO = 18'h00002;
    localparam logic [17:0] WAIT_BASE = 18'h00400;
    localparam logic [17:0] WAIT_STD_LONG = 18'h20000;
    localparam logic SUB_STOP_RST_STD = 1'b0;
    localparam logic SUB_STOP_RST_EXT = 1'b1;

    // Nominal slow oscillator rate; all waits count its cycles.
    localparam int SLOW_OSC_KHZ = 4000;
    localparam int CLK_SYS_KHZ = 10000;

    typedef struct packed {
        logic [2:0] slow_sync;
        logic slow_lvl;
        logic [3:0] periph_a_divider;
        logic [3:0] ext_bus_divider;
        logic bus_clock_pin_output_ctrl;
        logic [5:0] pll_multiply_factor;
        logic [1:0] pll_in_div;
        logic main_stop;
        logic pll_stop;
        logic usb_pll_stop;
        logic sub_oscillator_stop;
        logic [4:0] main_osc_wait_code;
        logic slow_force_run;
        logic main_ok;
        logic pll_ok;
        logic usb_pll_stable_flag;
        logic [17:0] main_cnt;
        logic [7:0] pll_cnt;
        logic [7:0] usb_cnt;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] rdata;
    } pwc_state_t;

endpackage : pwc_pkg

// [pwc_clk_cfg.sv]
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// [R01] Factor codes 000111 to 010111 give multiply-by-4 to 12 in half steps.
// [R02] Extended variant also takes codes 011000 to 011010, giving 12.5 to 13.5.
// [R03] Software writes only listed factor and wait codes; others are dropped here.
// [R04] Standard variant: wait code 00000 means no stabilization wait.
// [R05] Extended variant: wait code 00000 means a two-cycle wait.
// [R06] Wait codes 00001 to 00111 give 1,024 cycles doubling to 65,536.
// [R07] Standard variant only: wait code 01000 gives 131,072 cycles.
// [R08] Waits count cycles of the slow on-chip oscillator, nominally 4.0 MHz.
// [R09] Standard variant: sub oscillator stop bit cleared only by power-on reset.
// [R10] Extended variant adds periph-A and bus dividers and bus clock pin control.
// [R11] Extended variant reports a USB PLL stable flag; standard reads it zero.
// [R12] Standard variant alone has the slow oscillator force-run control.
// [R13] PLL input divider selects divide by 1, 2 or 4.
// [R14] Main stable flag sets after the wait, stays until oscillator stops.
// [R15] Factor writes act only while PLL stopped; PLL flag clears when stopped.
module pwc_clk_cfg import pwc_pkg::*; #(
    parameter bit EXTENDED = 1'b0,
    parameter logic [7:0] PLL_LOCK_TICKS = 8'h10,
    parameter logic [7:0] USB_LOCK_TICKS = 8'h10
) (
    // Clock and resets.
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic por_rst,
    // Slow on-chip oscillator clock, sampled as a level.
    input wire logic slow_internal_oscillator,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Oscillator and PLL controls.
    output logic main_osc_enable,
    output logic pll_enable,
    output logic usb_pll_enable,
    output logic sub_osc_enable,
    output logic slow_osc_force_run,
    output logic [5:0] pll_multiply_factor,
    output logic [1:0] pll_in_div,
    output logic [3:0] periph_a_divider,
    output logic [3:0] ext_bus_divider,
    output logic bus_clock_pin_output_ctrl,
    output logic main_osc_stable,
    output logic pll_stable,
    output logic usb_pll_stable_flag,
    // Interrupt.
    output logic irq
);

    localparam logic [5:0] MULT_MAX = EXTENDED ? MULT_CODE_EXT_MAX : MULT_CODE_STD_MAX;

    pwc_state_t s_q;
    pwc_state_t s_d;
    logic slow_tick;
    logic [2:0] ev;

    // Wait length in slow oscillator cycles for a legal code.
    function automatic logic [17:0] wait_cycles(input logic [4:0] code);
        logic [17:0] r;
        r = '0;
        if (code == 5'h00)
        begin
            r = EXTENDED ? WAIT_EXT_ZERO : WAIT_STD_ZERO; // [R04] [R05]
        end
        else if (code <= WAIT_CODE_DOUBLE_MAX)
        begin
            r = WAIT_BASE << (code - 5'h01); // [R06]
        end
        else
        begin
            r = WAIT_STD_LONG; // [R07]
        end
        return r;
    endfunction : wait_cycles

    // The long code exists only on the standard part.
    function automatic logic wait_legal(input logic [4:0] code);
        return (code <= WAIT_CODE_DOUBLE_MAX) || (!EXTENDED && code == WAIT_CODE_STD_LONG); // [R07]
    endfunction : wait_legal

    // Next state: synchroniser, register writes, stabilization counters, interrupts.
    always_comb
    begin
        s_d = s_q;
        slow_tick = 1'b0;
        ev = 3'h0;

        // Three stages; a level is accepted once stages two and three agree.
        // Stage one feeds only stage two, so a metastable sample never reaches the counters.
        s_d.slow_sync = {s_q.slow_sync[1:0], slow_internal_oscillator};
        if (s_q.slow_sync[1] == s_q.slow_sync[2] && s_q.slow_sync[2] != s_q.slow_lvl)
        begin
            s_d.slow_lvl = s_q.slow_sync[2];
            slow_tick = s_q.slow_sync[2]; // [R08]
        end

        // Register writes. Illegal codes are dropped so the PLL never sees them.
        if (reg_wr)
        begin
            case (reg_addr)
                OFS_SYS_CLK_DIV:
                begin
                    if (EXTENDED)
                    begin
                        s_d.periph_a_divider = reg_wdata[PA_DIV_LSB +: 4]; // [R10]
                        s_d.ext_bus_divider = reg_wdata[EB_DIV_LSB +: 4]; // [R10]
                        s_d.bus_clock_pin_output_ctrl = reg_wdata[BUS_PIN_BIT]; // [R10]
                    end
                end
                OFS_PLL_FACTOR:
                begin
                    // Changing the factor under a running PLL would upset lock.
                    if (s_q.pll_stop && reg_wdata[MULT_LSB +: 6] >= MULT_CODE_MIN
                        && reg_wdata[MULT_LSB +: 6] <= MULT_MAX)
                    begin
                        s_d.pll_multiply_factor = reg_wdata[MULT_LSB +: 6]; // [R01] [R02] [R03] [R15]
                    end
                    if (s_q.pll_stop && reg_wdata[IN_DIV_LSB +: 2] != IN_DIV_ILLEGAL)
                    begin
                        s_d.pll_in_div = reg_wdata[IN_DIV_LSB +: 2]; // [R13]
                    end
                end
                OFS_OSC_RUN:
                begin
                    s_d.main_stop = reg_wdata[RUN_MAIN_STOP_BIT];
                    s_d.pll_stop = reg_wdata[RUN_PLL_STOP_BIT];
                    s_d.usb_pll_stop = EXTENDED ? reg_wdata[RUN_USB_STOP_BIT] : 1'b1;
                end
                OFS_SUB_OSC_STOP:
                begin
                    s_d.sub_oscillator_stop = reg_wdata[0];
                end
                OFS_MAIN_WAIT:
                begin
                    if (wait_legal(reg_wdata[4:0]))
                    begin
                        s_d.main_osc_wait_code = reg_wdata[4:0]; // [R03]
                    end
                end
                OFS_SLOW_FORCE:
                begin
                    s_d.slow_force_run = EXTENDED ? 1'b0 : reg_wdata[0]; // [R12]
                end
                OFS_IRQ_MASK:
                begin
                    s_d.irq_mask = reg_wdata[2:0];
                end
                // Status, read-only and unmapped offsets ignore writes here.
                default:
                begin
                    s_d.rdata = s_q.rdata;
                end
            endcase
        end

        // Main oscillator wait counts slow oscillator rising edges after start.
        if (s_q.main_stop)
        begin
            s_d.main_ok = 1'b0; // [R14]
            s_d.main_cnt = '0;
        end
        else if (!s_q.main_ok)
        begin
            if (s_q.main_cnt >= wait_cycles(s_q.main_osc_wait_code))
            begin
                s_d.main_ok = 1'b1; // [R14]
            end
            else if (slow_tick)
            begin
                s_d.main_cnt = s_q.main_cnt + 18'h00001; // [R08]
            end
        end

        // The PLL needs a stable main clock; stopping it drops the flag at once.
        if (s_q.pll_stop || !s_q.main_ok)
        begin
            s_d.pll_ok = 1'b0; // [R15]
            s_d.pll_cnt = '0;
        end
        else if (!s_q.pll_ok)
        begin
            if (s_q.pll_cnt >= PLL_LOCK_TICKS)
            begin
                s_d.pll_ok = 1'b1;
            end
            else if (slow_tick)
            begin
                s_d.pll_cnt = s_q.pll_cnt + 8'h01;
            end
        end

        // USB PLL exists only on the extended part.
        if (!EXTENDED || s_q.usb_pll_stop || !s_q.main_ok)
        begin
            s_d.usb_pll_stable_flag = 1'b0; // [R11]
            s_d.usb_cnt = '0;
        end
        else if (!s_q.usb_pll_stable_flag)
        begin
            if (s_q.usb_cnt >= USB_LOCK_TICKS)
            begin
                s_d.usb_pll_stable_flag = 1'b1; // [R11]
            end
            else if (slow_tick)
            begin
                s_d.usb_cnt = s_q.usb_cnt + 8'h01;
            end
        end

        // Rising stable flags set sticky bits; a set beats a same-cycle clear.
        ev[ST_MAIN_BIT] = s_d.main_ok & ~s_q.main_ok;
        ev[ST_PLL_BIT] = s_d.pll_ok & ~s_q.pll_ok;
        ev[ST_USB_BIT] = s_d.usb_pll_stable_flag & ~s_q.usb_pll_stable_flag;
        s_d.irq_stat = s_q.irq_stat;
        if (reg_wr && reg_addr == OFS_IRQ_STATUS)
        begin
            s_d.irq_stat = s_q.irq_stat & ~reg_wdata[2:0];
        end
        s_d.irq_stat = s_d.irq_stat | ev;

        // Read data appears in the cycle after the strobe only.
        s_d.rdata = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                OFS_SYS_CLK_DIV:
                begin
                    s_d.rdata[PA_DIV_LSB +: 4] = s_q.periph_a_divider;
                    s_d.rdata[EB_DIV_LSB +: 4] = s_q.ext_bus_divider;
                    s_d.rdata[BUS_PIN_BIT] = s_q.bus_clock_pin_output_ctrl;
                end
                OFS_PLL_FACTOR:
                begin
                    s_d.rdata[MULT_LSB +: 6] = s_q.pll_multiply_factor;
                    s_d.rdata[IN_DIV_LSB +: 2] = s_q.pll_in_div;
                end
                OFS_OSC_RUN:
                begin
                    s_d.rdata[RUN_MAIN_STOP_BIT] = s_q.main_stop;
                    s_d.rdata[RUN_PLL_STOP_BIT] = s_q.pll_stop;
                    s_d.rdata[RUN_USB_STOP_BIT] = s_q.usb_pll_stop;
                end
                OFS_SUB_OSC_STOP: s_d.rdata[0] = s_q.sub_oscillator_stop;
                OFS_OSC_STABLE:
                begin
                    s_d.rdata[ST_MAIN_BIT] = s_q.main_ok;
                    s_d.rdata[ST_PLL_BIT] = s_q.pll_ok;
                    s_d.rdata[ST_USB_BIT] = s_q.usb_pll_stable_flag; // [R11]
                end
                OFS_MAIN_WAIT: s_d.rdata[4:0] = s_q.main_osc_wait_code;
                OFS_SLOW_FORCE: s_d.rdata[0] = s_q.slow_force_run;
                OFS_IRQ_STATUS: s_d.rdata[2:0] = s_q.irq_stat;
                OFS_IRQ_MASK: s_d.rdata[2:0] = s_q.irq_mask;
                default: s_d.rdata = '0;
            endcase
        end

        // Reset. On the standard part only power-on clears the sub oscillator stop.
        if (srst || por_rst)
        begin
            s_d = '0;
            s_d.pll_multiply_factor = MULT_RST;
            s_d.main_stop = 1'b1;
            s_d.pll_stop = 1'b1;
            s_d.usb_pll_stop = 1'b1;
            s_d.main_osc_wait_code = WAIT_RST;
            s_d.sub_oscillator_stop = EXTENDED ? SUB_STOP_RST_EXT : SUB_STOP_RST_STD;
            if (!EXTENDED && !por_rst)
            begin
                s_d.sub_oscillator_stop = s_q.sub_oscillator_stop; // [R09]
            end
        end
    end

    // Every register of the block lives in the one state word.
    always_ff @(posedge clk_sys)
    begin
        s_q <= s_d;
    end

    // Outputs straight from state.
    assign reg_rdata = s_q.rdata;
    assign main_osc_enable = ~s_q.main_stop;
    assign pll_enable = ~s_q.pll_stop;
    assign usb_pll_enable = ~s_q.usb_pll_stop;
    assign sub_osc_enable = ~s_q.sub_oscillator_stop;
    assign slow_osc_force_run = s_q.slow_force_run;
    assign pll_multiply_factor = s_q.pll_multiply_factor;
    assign pll_in_div = s_q.pll_in_div;
    assign periph_a_divider = s_q.periph_a_divider;
    assign ext_bus_divider = s_q.ext_bus_divider;
    assign bus_clock_pin_output_ctrl = s_q.bus_clock_pin_output_ctrl;
    assign main_osc_stable = s_q.main_ok;
    assign pll_stable = s_q.pll_ok;
    assign usb_pll_stable_flag = s_q.usb_pll_stable_flag;
    assign irq = |(s_q.irq_stat & s_q.irq_mask);

endmodule : pwc_clk_cfg

// [pwc_clk_cfg_chk.sv]
`timescale 1ns/1ps
module pwc_clk_cfg_chk #(
    parameter bit EXTENDED = 1'b0
) (
    // Clock and resets.
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic por_rst,
    // Register strobes and read data.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Controls and flags.
    input wire logic main_osc_enable,
    input wire logic pll_enable,
    input wire logic [5:0] pll_multiply_factor,
    input wire logic [3:0] periph_a_divider,
    input wire logic main_osc_stable,
    input wire logic pll_stable,
    input wire logic usb_pll_stable_flag,
    input wire logic irq
);
    // All checks share the one clock; either reset silences them.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst || por_rst);

    // Read data is zero outside the slot after a read, so stale words never leak.
    property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
    property p_mult_ok; pll_multiply_factor >= 6'h07 && pll_multiply_factor <= (EXTENDED ? 6'h1A : 6'h17); endproperty
    a_mult_ok: assert property (p_mult_ok) else $error("factor code off the table");
    property p_mult_frozen; pll_enable |=> $stable(pll_multiply_factor); endproperty
    a_mult_frozen: assert property (p_mult_frozen) else $error("factor moved while running");
    property p_pll_clear; !pll_enable |=> !pll_stable; endproperty
    a_pll_clear: assert property (p_pll_clear) else $error("pll flag kept while stopped");
    property p_main_clear; !main_osc_enable |=> !main_osc_stable; endproperty
    a_main_clear: assert property (p_main_clear) else $error("main flag kept while stopped");
    property p_main_hold; main_osc_stable && main_osc_enable ##1 main_osc_enable |-> main_osc_stable; endproperty
    a_main_hold: assert property (p_main_hold) else $error("main flag dropped while running");
    // A zero wait lets the flag rise one cycle after the start, so look back only one cycle.
    property p_main_rise; $rose(main_osc_stable) |-> $past(main_osc_enable); endproperty
    a_main_rise: assert property (p_main_rise) else $error("main flag rose too early");
    property p_pll_rise; $rose(pll_stable) |-> main_osc_stable && $past(pll_enable, 2); endproperty
    a_pll_rise: assert property (p_pll_rise) else $error("pll flag rose without cause");
    property p_std_only; !EXTENDED |-> periph_a_divider == 4'h0 && !usb_pll_stable_flag; endproperty
    a_std_only: assert property (p_std_only) else $error("extended field on standard part");
    property p_irq_cause;
        $rose(irq) |-> $rose(main_osc_stable) || $rose(pll_stable) || $rose(usb_pll_stable_flag) || $past(reg_wr);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without event");
endmodule : pwc_clk_cfg_chk

bind pwc_clk_cfg pwc_clk_cfg_chk #(.EXTENDED(EXTENDED)) pwc_clk_cfg_chk_i (
    .clk_sys(clk_sys), .srst(srst), .por_rst(por_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .main_osc_enable(main_osc_enable), .pll_enable(pll_enable),
    .pll_multiply_factor(pll_multiply_factor), .periph_a_divider(periph_a_divider),
    .main_osc_stable(main_osc_stable), .pll_stable(pll_stable),
    .usb_pll_stable_flag(usb_pll_stable_flag), .irq(irq));

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    // Inputs, valued at time zero; s and e name the standard and extended parts.
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic por_rst = 1'b1;
    logic slow_clk = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] rdata_s, rdata_e, lfsr_q = 32'h0D38953A;
    logic stab_s, stab_e, irq_s, irq_e;
    logic [1:0] div_s;
    logic sub_s, frc_s, frc_e, bp_e, usb_e;
    logic [3:0] pa_e, eb_e;
    logic [5:0] mf_s;
    logic [5:0] c, mult_s = 6'h07, mult_e = 6'h07;
    logic [4:0] wait_s = 5'h05, wait_e = 5'h05;
    logic [5:0] corner [8] = '{6'h06, 6'h07, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h3F};
    int miscompares = 0;
    int num_checks = 0;
    int n;

    // The slow clock runs below nominal so the sampler sees every edge; waits count its ticks.
    always #50 clk_sys = ~clk_sys;
    always #400 slow_clk = ~slow_clk;

    pwc_clk_cfg #(.EXTENDED(1'b0), .PLL_LOCK_TICKS(8'h02)) pwc_clk_cfg_i (
        .clk_sys(clk_sys), .srst(srst), .por_rst(por_rst), .slow_internal_oscillator(slow_clk),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_s),
        .main_osc_enable(), .pll_enable(), .usb_pll_enable(), .sub_osc_enable(sub_s), .slow_osc_force_run(frc_s),
        .pll_multiply_factor(mf_s), .pll_in_div(div_s), .periph_a_divider(), .ext_bus_divider(),
        .bus_clock_pin_output_ctrl(), .main_osc_stable(stab_s), .pll_stable(), .usb_pll_stable_flag(), .irq(irq_s));
    pwc_clk_cfg #(.EXTENDED(1'b1), .PLL_LOCK_TICKS(8'h02), .USB_LOCK_TICKS(8'h02)) pwc_clk_cfg_ext_i (
        .clk_sys(clk_sys), .srst(srst), .por_rst(por_rst), .slow_internal_oscillator(slow_clk),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_e),
        .main_osc_enable(), .pll_enable(), .usb_pll_enable(), .sub_osc_enable(), .slow_osc_force_run(frc_e),
        .pll_multiply_factor(), .pll_in_div(), .periph_a_divider(pa_e), .ext_bus_divider(eb_e),
        .bus_clock_pin_output_ctrl(bp_e), .main_osc_stable(stab_e), .pll_stable(),
        .usb_pll_stable_flag(usb_e), .irq(irq_e));

    // Illegal codes are dropped, so the model keeps the old value.
    function automatic logic [5:0] exp_mult(input logic [5:0] k, input logic [5:0] old, input logic ext);
        return (k >= 6'h07 && k <= (ext ? 6'h1A : 6'h17)) ? k : old;
    endfunction : exp_mult

    function automatic logic [4:0] exp_wait(input logic [4:0] k, input logic [4:0] old, input logic ext);
        return (k <= (ext ? 5'h07 : 5'h08)) ? k : old;
    endfunction : exp_wait

    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction : rnd

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data is sampled in its only valid cycle, once the edge has settled.
    task automatic rd(input logic [7:0] a, input logic [31:0] ws, input logic [31:0] we);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(rdata_s, ws);
        chk(rdata_e, we);
    endtask : rd

    task automatic do_reset(input logic por);
        srst <= 1'b1;
        por_rst <= por;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        por_rst <= 1'b0;
    endtask : do_reset

    task automatic close_out();
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    // Main sequence.
    initial
    begin
        do_reset(1'b1);
        rd(8'h04, 32'h700, 32'h700);
        rd(8'h0C, 32'h0, 32'h1);
        rd(8'h40, 32'h0, 32'h0);
        $display("done: reset values");
        for (int i = 0; i < 40; i++)
        begin
            lfsr_q = rnd();
            c = (i < 8) ? corner[i] : lfsr_q[5:0];
            wr(8'h04, {18'h0, c, 8'h00});
            mult_s = exp_mult(c, mult_s, 1'b0);
            mult_e = exp_mult(c, mult_e, 1'b1);
            rd(8'h04, {18'h0, mult_s, 8'h00}, {18'h0, mult_e, 8'h00});
            chk(mf_s, mult_s);
        end
        for (int d = 0; d < 3; d++)
        begin
            wr(8'h04, {18'h0, mult_s, 6'h0, d[1:0]});
            #1;
            chk({30'h0, div_s}, d);
        end
        for (int i = 0; i < 32; i++)
        begin
            wr(8'h14, i);
            wait_s = exp_wait(i[4:0], wait_s, 1'b0);
            wait_e = exp_wait(i[4:0], wait_e, 1'b1);
            rd(8'h14, {27'h0, wait_s}, {27'h0, wait_e});
        end
        wr(8'h00, 32'h0F8F0000);
        rd(8'h00, 32'h0, 32'h0F8F0000);
        chk({pa_e, bp_e, eb_e}, 9'h1FF);
        wr(8'h18, 32'h1);
        rd(8'h18, 32'h1, 32'h0);
        chk({frc_s, frc_e}, 2'b10);
        $display("done: codes and fields");
        wr(8'h14, 32'h0);
        wr(8'h20, 32'h1);
        wr(8'h08, 32'h6);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({stab_s, stab_e, irq_s}, 3'b101);
        // Flags are looked at just after the edge, once they have settled.
        for (n = 0; stab_e !== 1'b1 && n < 40; n++)
        begin
            @(posedge clk_sys);
            #1;
        end
        chk(n >= 4 && n < 40, 1);
        chk(irq_e, 1'b1);
        rd(8'h1C, 32'h1, 32'h1);
        wr(8'h1C, 32'h1);
        #1;
        chk({irq_s, irq_e}, 2'b00);
        wr(8'h08, 32'h0);
        repeat (40) @(posedge clk_sys);
        rd(8'h10, 32'h3, 32'h7);
        chk(usb_e, 1'b1);
        wr(8'h04, 32'h0900);
        rd(8'h04, {18'h0, mult_s, 8'h02}, {18'h0, mult_s, 8'h02});
        wr(8'h08, 32'h7);
        rd(8'h10, 32'h0, 32'h0);
        $display("done: stabilization flags");
        wr(8'h14, 32'h1);
        wr(8'h08, 32'h6);
        for (n = 0; stab_s !== 1'b1 && n < 9000; n++)
        begin
            @(posedge clk_sys);
            #1;
        end
        chk(n >= 8180 && n <= 8215, 1);
        wr(8'h0C, 32'h1);
        do_reset(1'b0);
        rd(8'h0C, 32'h1, 32'h1);
        chk(sub_s, 1'b0);
        do_reset(1'b1);
        rd(8'h0C, 32'h0, 32'h1);
        chk(sub_s, 1'b1);
        $display("done: long wait and resets");
        close_out();
    end

    // Watchdog well beyond the expected run of about 8,600 cycles.
    initial
    begin
        #3000000;
        miscompares++;
        close_out();
    end
endmodule : tb_top
